// File: logic/tscan_top.sv
// Touch-sense scan counter: prescaler, modulus counter, 16-bit accumulator.
// Assumes the electrode oscillator arrives unsynchronised on elec_osc_i.
//
// What this block does
// - Electrode oscillator passes a prescaler chosen by prescale_select.
// - Sampling interval is modulus counter running from zero to scan_count.
// - Result is reference clock periods counted during the interval.
// - Scanning works in run and wait only with module_enable_bit set.
// - In stop3, scanning continues only if stop_mode_enable is set.
// - Trigger select clear: software strobe starts scan of selected channel.
// - Trigger select set: no scan starts until a hardware trigger.
// - Chip hardware trigger, e.g. counter overflow, starts hardware scans.
// - Scans per measurement 1 to 32; field value 0 means one scan.
// - All scans summed in a 16-bit accumulator, read as high/low bytes.
// - Reference clock is the only operating clock and ticks the counter.
// - Several prescaler settings, division ratios up to 128.
// - Reference current select drives reference current independently.
// - Scan-in-progress status sets as soon as a scan begins.
// - End-of-scan flag sets on completion; read counts before clearing.
// - With scan_irq_enable set, end of scan raises the interrupt.
`timescale 1ns/1ns
module tscan_top
#(
	parameter int CHANNELS = 16
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        elec_osc_i,
	input  wire logic        hw_trigger_i,
	input  wire logic        stop3_i,
	output logic      [3:0]  channel_select_o,
	output logic      [15:0] electrode_pin_enable_o,
	output logic      [2:0]  electrode_current_select_o,
	output logic      [2:0]  reference_current_select_o,
	output logic             osc_enable_o,
	output logic             scan_irq_o
);
	import tscan_pkg::*;

	if (CHANNELS < 1 || CHANNELS > 16)
	begin
		$error("CHANNELS must be 1 to 16");
	end

	typedef enum logic [1:0] {ST_IDLE, ST_SCAN} tscan_state_type;

	tscan_state_type state_q;
	logic            module_enable_bit_q;
	logic            stop_mode_enable_q;
	logic            trigger_select_q;
	logic            scan_irq_enable_q;
	logic            end_of_scan_flag_q;
	logic            scan_in_progress_q;
	logic [4:0]      scan_count_q;
	logic [2:0]      prescale_select_q;
	logic [2:0]      ecur_q;
	logic [2:0]      rcur_q;
	logic [3:0]      chan_q;
	logic [15:0]     pinen_q;
	logic [15:0]     acc_q;
	logic [15:0]     result_q;
	logic [6:0]      pre_q;
	logic [4:0]      mod_q;
	logic [4:0]      scans_done_q;
	logic [2:0]      osc_sync_q;
	logic [1:0]      trg_sync_q;
	logic            trg_prev_q;
	logic [1:0]      stop_sync_q;

	logic            wr;
	logic            rd_ack;
	logic            sw_trig;
	logic            hw_edge;
	logic            start;
	logic            active;
	logic            osc_edge;
	logic            pre_tick;
	logic            interval_end;
	logic            seq_end;
	logic [6:0]      pre_mask;

	assign wr      = cyc_i && stb_i && we_i && !ack_o;
	assign rd_ack  = cyc_i && stb_i && !ack_o;

	// Oscillator and trigger are asynchronous: two flops, then edge detect
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			osc_sync_q  <= 3'h0;
			trg_sync_q  <= 2'h0;
			trg_prev_q  <= 1'b0;
			stop_sync_q <= 2'h0;
		end
		else
		begin
			osc_sync_q  <= {osc_sync_q[1:0], elec_osc_i};
			trg_sync_q  <= {trg_sync_q[0], hw_trigger_i};
			trg_prev_q  <= trg_sync_q[1];
			stop_sync_q <= {stop_sync_q[0], stop3_i};
		end
	end

	assign osc_edge = osc_sync_q[1] && !osc_sync_q[2];
	assign hw_edge  = trg_sync_q[1] && !trg_prev_q;

	// In stop3 the block runs only with stop enable; otherwise module enable
	assign active  = module_enable_bit_q
		&& (!stop_sync_q[1] || stop_mode_enable_q);
	assign sw_trig = wr && (adr_i == ADDR_CTRL) && sel_i[0]
		&& dat_i[CTRL_SWTRIG] && !dat_i[CTRL_TRIGSEL]
		&& !trigger_select_q;
	assign start   = active && (state_q == ST_IDLE)
		&& (trigger_select_q ? hw_edge : sw_trig);

	// Divide by 2^prescale_select: 1 to 128
	assign pre_mask = 7'((8'h01 << prescale_select_q) - 8'h01);
	assign pre_tick = osc_edge && ((pre_q & pre_mask) == pre_mask);
	assign interval_end = pre_tick && (mod_q == scan_count_q);
	assign seq_end  = interval_end && (scans_done_q == scan_count_q);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_q <= ST_IDLE;
		else if (!active)
			state_q <= ST_IDLE;
		else if (start)
			state_q <= ST_SCAN;
		else if (state_q == ST_SCAN && seq_end)
			state_q <= ST_IDLE;
	end

	// Prescaler and modulus counter run only during a scan
	always_ff @(posedge clk_i)
	begin
		if (rst_i || start)
		begin
			pre_q <= 7'h00;
			mod_q <= 5'h00;
			scans_done_q <= 5'h00;
		end
		else if (state_q == ST_SCAN && osc_edge)
		begin
			pre_q <= pre_q + 7'h01;
			if (pre_tick)
			begin
				if (interval_end)
				begin
					mod_q <= 5'h00;
					scans_done_q <= scans_done_q + 5'h01;
				end
				else
					mod_q <= mod_q + 5'h01;
			end
		end
	end

	// Reference clock counts every cycle of the sampling interval
	always_ff @(posedge clk_i)
	begin
		if (rst_i || start)
			acc_q <= 16'h0000;
		else if (state_q == ST_SCAN)
			acc_q <= acc_q + 16'h0001;
	end

	// Result latched at sequence end, so a read mid-scan stays stable
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			result_q <= 16'h0000;
		else if (state_q == ST_SCAN && seq_end)
			result_q <= acc_q + 16'h0001;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			scan_in_progress_q <= 1'b0;
		else
			scan_in_progress_q <= start
				|| (state_q == ST_SCAN && !seq_end && active);
	end

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			end_of_scan_flag_q <= 1'b0;
		else if (state_q == ST_SCAN && seq_end)
			end_of_scan_flag_q <= 1'b1;
		else if (wr && adr_i == ADDR_CTRL && sel_i[0] && dat_i[CTRL_END_OF_SCAN_FLAG])
			end_of_scan_flag_q <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			scan_irq_o <= 1'b0;
		else
			scan_irq_o <= end_of_scan_flag_q && scan_irq_enable_q;
	end

	// Control and configuration writes; strobe bit is never stored
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			module_enable_bit_q <= CTRL_RESET[CTRL_EN];
			stop_mode_enable_q  <= CTRL_RESET[CTRL_STOPEN];
			trigger_select_q    <= CTRL_RESET[CTRL_TRIGSEL];
			scan_irq_enable_q   <= CTRL_RESET[CTRL_IRQEN];
			scan_count_q        <= CFG_RESET[CFG_SCAN_COUNT_LSB +: 5];
			prescale_select_q   <= CFG_RESET[CFG_PS_LSB +: 3];
			ecur_q              <= CFG_RESET[CFG_ECUR_LSB +: 3];
			rcur_q              <= CFG_RESET[CFG_RCUR_LSB +: 3];
			chan_q              <= 4'h0;
			pinen_q             <= 16'h0000;
		end
		else if (wr)
		begin
			if (adr_i == ADDR_CTRL && sel_i[0])
			begin
				module_enable_bit_q <= dat_i[CTRL_EN];
				stop_mode_enable_q  <= dat_i[CTRL_STOPEN];
				trigger_select_q    <= dat_i[CTRL_TRIGSEL];
				scan_irq_enable_q   <= dat_i[CTRL_IRQEN];
			end
			if (adr_i == ADDR_CFG)
			begin
				if (sel_i[0])
				begin
					scan_count_q      <= dat_i[CFG_SCAN_COUNT_LSB +: 5];
					prescale_select_q <= dat_i[CFG_PS_LSB +: 3];
				end
				if (sel_i[1])
				begin
					ecur_q <= dat_i[CFG_ECUR_LSB +: 3];
					rcur_q <= dat_i[CFG_RCUR_LSB +: 3];
				end
			end
			if (adr_i == ADDR_CHAN && sel_i[0])
				chan_q <= dat_i[3:0];
			if (adr_i == ADDR_PINEN)
			begin
				if (sel_i[0])
					pinen_q[7:0] <= dat_i[7:0];
				if (sel_i[1])
					pinen_q[15:8] <= dat_i[15:8];
			end
		end
	end

	// Read path and single-cycle ack
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= rd_ack;
			if (rd_ack && !we_i)
			begin
				unique case (adr_i)
					ADDR_CTRL:   dat_o <= {25'h0, scan_in_progress_q,
						end_of_scan_flag_q, scan_irq_enable_q, 1'b0,
						trigger_select_q, stop_mode_enable_q,
						module_enable_bit_q};
					ADDR_CFG:    dat_o <= {18'h0, rcur_q, ecur_q,
						prescale_select_q, scan_count_q};
					ADDR_CHAN:   dat_o <= {28'h0, chan_q};
					ADDR_PINEN:  dat_o <= {16'h0, pinen_q};
					ADDR_CNT_HI: dat_o <= {24'h0, result_q[15:8]};
					ADDR_CNT_LO: dat_o <= {24'h0, result_q[7:0]};
					ADDR_STATUS: dat_o <= {27'h0, scans_done_q};
					default:     dat_o <= UNMAPPED_DATA;
				endcase
			end
		end
	end

	// Pin and current controls to the analog front end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			channel_select_o           <= 4'h0;
			electrode_pin_enable_o     <= 16'h0000;
			electrode_current_select_o <= 3'h0;
			reference_current_select_o <= 3'h0;
			osc_enable_o               <= 1'b0;
		end
		else
		begin
			channel_select_o           <= chan_q;
			electrode_pin_enable_o     <= pinen_q;
			electrode_current_select_o <= ecur_q;
			reference_current_select_o <= rcur_q;
			osc_enable_o               <= active;
		end
	end
endmodule

// File: logic/tscan_pkg.sv
// Package for the touch-sense scan counter: register map, fields, resets.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package tscan_pkg;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_CFG      = 8'h04;
	localparam logic [7:0]  ADDR_CHAN     = 8'h08;
	localparam logic [7:0]  ADDR_PINEN    = 8'h0C;
	localparam logic [7:0]  ADDR_CNT_HI   = 8'h10;
	localparam logic [7:0]  ADDR_CNT_LO   = 8'h14;
	localparam logic [7:0]  ADDR_STATUS   = 8'h18;
	// Control register bits
	localparam int          CTRL_EN       = 0;
	localparam int          CTRL_STOPEN   = 1;
	localparam int          CTRL_TRIGSEL  = 2;
	localparam int          CTRL_SWTRIG   = 3;
	localparam int          CTRL_IRQEN    = 4;
	localparam int          CTRL_END_OF_SCAN_FLAG     = 5;
	localparam int          CTRL_SCAN_IN_PROGRESS    = 6;
	// Config register fields
	localparam int          CFG_SCAN_COUNT_LSB  = 0;
	localparam int          CFG_PS_LSB    = 5;
	localparam int          CFG_ECUR_LSB  = 8;
	localparam int          CFG_RCUR_LSB  = 11;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	localparam int          PS_MAX_LOG2   = 7;
	localparam int          SCAN_MAX      = 32;
	localparam logic [4:0]  MOD_MAX       = 5'h1F;
endpackage

// File: verification/tscan_chk.sv
// Checker: bus timing and register copies of tscan_top.
// Sees only the top ports; bound from the bench.
`timescale 1ns/1ns
module tscan_chk
	import tscan_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [3:0]  channel_select_o,
	input wire logic [2:0]  reference_current_select_o,
	input wire logic [2:0]  electrode_current_select_o,
	input wire logic        osc_enable_o,
	input wire logic        scan_irq_o
);
	wire req = cyc_i && stb_i && !ack_o;
	wire wr0 = req && we_i && sel_i[0];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (req |=> ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_no_stray: assert property (!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	a_chan_copy: assert property (
		wr0 && adr_i == ADDR_CHAN |=> ##1
		channel_select_o == $past(dat_i[3:0], 2))
		else $error("channel copy wrong");
	a_cur_copy: assert property (
		req && we_i && sel_i[1] && adr_i == ADDR_CFG |=> ##1
		reference_current_select_o == $past(dat_i[13:11], 2) &&
		electrode_current_select_o == $past(dat_i[10:8], 2))
		else $error("current copy wrong");
	a_osc_gate: assert property (
		wr0 && adr_i == ADDR_CTRL && !dat_i[CTRL_EN] |=> ##1 !osc_enable_o)
		else $error("oscillator on while disabled");
	a_irq_gate: assert property (
		wr0 && adr_i == ADDR_CTRL && !dat_i[CTRL_IRQEN] |=> ##1 !scan_irq_o)
		else $error("irq while masked");
	a_strobe_zero: assert property (
		req && !we_i && adr_i == ADDR_CTRL |=> !dat_o[CTRL_SWTRIG])
		else $error("trigger strobe reads one");
	a_reset_quiet: assert property (disable iff (1'h0)
		rst_i |=> !ack_o && !scan_irq_o && !osc_enable_o)
		else $error("outputs active after reset");
endmodule

// File: verification/tscan_elec.sv
// Electrode oscillator model: square wave while enabled.
// Assumes osc_enable_o of the scan counter gates it.
`timescale 1ns/1ns
module tscan_elec
#(
	parameter int HALF_NS = 60
)
(
	input  wire logic enable_i,
	output logic      osc_o
);
	// Stopped oscillator rests low
	initial
	begin
		osc_o = 1'h0;
		forever
		begin
			#(HALF_NS);
			osc_o = enable_i ? !osc_o : 1'h0;
		end
	end
endmodule

// File: verification/tb_top.sv
// Bench for tscan_top: Wishbone tasks and scan cases.
// Assumes tscan_chk and tscan_elec are compiled first.
`timescale 1ns/1ns
module tb_top;
	import tscan_pkg::*;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0]  adr_i = 0;
	logic [3:0]  sel_i = 0, channel_select_o;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic        ack_o, hw_trigger_i = 0, stop3_i = 0, elec_osc_i;
	logic        osc_enable_o, scan_irq_o;
	logic [15:0] electrode_pin_enable_o;
	logic [2:0]  electrode_current_select_o, reference_current_select_o;
	int          n_mismatch = 0, tests_run = 0;
	logic [7:0]  cfgs [6] = '{8'h00, 8'h21, 8'h43, 8'hE0, 8'h1F, 8'h02};
	logic [7:0]  ctls [6] = '{8'h09, 8'h19, 8'h09, 8'h09, 8'h19, 8'h0D};
	tscan_top dut_u
	(
		.clk_i                      (clk_i),
		.rst_i                      (rst_i),
		.cyc_i                      (cyc_i),
		.stb_i                      (stb_i),
		.we_i                       (we_i),
		.adr_i                      (adr_i),
		.sel_i                      (sel_i),
		.dat_i                      (dat_i),
		.dat_o                      (dat_o),
		.ack_o                      (ack_o),
		.elec_osc_i                 (elec_osc_i),
		.hw_trigger_i               (hw_trigger_i),
		.stop3_i                    (stop3_i),
		.channel_select_o           (channel_select_o),
		.electrode_pin_enable_o     (electrode_pin_enable_o),
		.electrode_current_select_o (electrode_current_select_o),
		.reference_current_select_o (reference_current_select_o),
		.osc_enable_o               (osc_enable_o),
		.scan_irq_o                 (scan_irq_o)
	);
	// Oscillator period 6 clocks, well below the reference rate
	tscan_elec elec_u (.enable_i(osc_enable_o), .osc_o(elec_osc_i));
	always #10 clk_i = ~clk_i;
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Start phase of the oscillator is free, hence the tolerance
	task automatic chk_near(input logic [15:0] got, input int exp);
		int g;
		// Signed compare, so a small expectation cannot wrap
		g = int'(got);
		tests_run++;
		if ($isunknown(got) || g < exp - 10 || g > exp + 10)
		begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits for ack however long it takes; a hang is the watchdog's
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do
		begin
			@(posedge clk_i);
		end
		while (ack_o !== 1'h1);
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic scan(input logic [7:0] cfg, input logic [31:0] ctl);
		int e, i;
		logic [7:0] hi;
		e = (cfg[4:0] + 1) * (cfg[4:0] + 1) * (1 << cfg[7:5]);
		bus(1'h1, ADDR_CFG, {24'h000038, cfg}, 4'hF);
		bus(1'h1, ADDR_CTRL, ctl, 4'hF);
		if (ctl[CTRL_TRIGSEL])
		begin
			bus(1'h0, ADDR_CTRL, 0, 4'hF);
			chk(rd, ctl & ~32'h8);
			hw_trigger_i <= 1'h1;
			repeat (4) @(posedge clk_i);
			hw_trigger_i <= 1'h0;
		end
		bus(1'h0, ADDR_CTRL, 0, 4'hF);
		if (e > 8)
			chk(rd[CTRL_SCAN_IN_PROGRESS], 1'h1);
		for (i = 0; i < 3000 && rd[CTRL_END_OF_SCAN_FLAG] !== 1'h1; i++)
			bus(1'h0, ADDR_CTRL, 0, 4'hF);
		chk(rd, ctl & ~32'h8 | 32'h20);
		bus(1'h0, ADDR_CNT_HI, 0, 4'hF);
		hi = rd[7:0];
		bus(1'h0, ADDR_CNT_LO, 0, 4'hF);
		chk_near({hi, rd[7:0]}, e * 6);
		chk(scan_irq_o, ctl[CTRL_IRQEN]);
		bus(1'h1, ADDR_CTRL, ctl & ~32'h8 | 32'h20, 4'hF);
		bus(1'h0, ADDR_CTRL, 0, 4'hF);
		chk(rd, ctl & ~32'h8);
		chk(scan_irq_o, 1'h0);
	endtask
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		bus(1'h0, ADDR_CTRL, 0, 4'hF);
		chk(rd, CTRL_RESET);
		bus(1'h1, ADDR_CFG, 32'h3FFF, 4'hF);
		bus(1'h1, ADDR_CFG, 32'h0, 4'h1);
		bus(1'h0, ADDR_CFG, 0, 4'hF);
		chk(rd, 32'h3F00);
		chk(reference_current_select_o, 3'h7);
		bus(1'h1, ADDR_CHAN, 32'h5, 4'hF);
		// Only the scanned electrode is enabled, the others stay idle
		bus(1'h1, ADDR_PINEN, 32'h20, 4'hF);
		chk(channel_select_o, 4'h5);
		chk(electrode_pin_enable_o, 16'h0020);
		bus(1'h0, 8'h1C, 0, 4'hF);
		chk(rd, UNMAPPED_DATA);
		bus(1'h1, ADDR_CTRL, 32'h8, 4'hF);
		repeat (8) @(posedge clk_i);
		bus(1'h0, ADDR_CTRL, 0, 4'hF);
		chk(rd, 32'h0);
		stop3_i <= 1'h1;
		bus(1'h1, ADDR_CTRL, 32'h1, 4'hF);
		repeat (5) @(posedge clk_i);
		chk(osc_enable_o, 1'h0);
		bus(1'h1, ADDR_CTRL, 32'h3, 4'hF);
		repeat (5) @(posedge clk_i);
		chk(osc_enable_o, 1'h1);
		stop3_i <= 1'h0;
		for (int k = 0; k < 6; k++)
			scan(cfgs[k], ctls[k]);
		print_verdict();
	end
	initial
	begin
		repeat (40000) @(posedge clk_i);
		n_mismatch++;
		print_verdict();
	end
endmodule
bind tscan_top tscan_chk chk_u
(
	.clk_i                      (clk_i),
	.rst_i                      (rst_i),
	.cyc_i                      (cyc_i),
	.stb_i                      (stb_i),
	.we_i                       (we_i),
	.adr_i                      (adr_i),
	.sel_i                      (sel_i),
	.dat_i                      (dat_i),
	.dat_o                      (dat_o),
	.ack_o                      (ack_o),
	.channel_select_o           (channel_select_o),
	.reference_current_select_o (reference_current_select_o),
	.electrode_current_select_o (electrode_current_select_o),
	.osc_enable_o               (osc_enable_o),
	.scan_irq_o                 (scan_irq_o)
);
